// ==== core/pcs_config_pins.sv ====
// Configuration strap and status pin logic with a small register port
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - The strap mode select level picks hardware mode when low and software mode when high.
// R2 - In hardware mode the speed pin is an input, low for 10 Mb/s and high for 100 Mb/s.
// R3 - In software mode the speed pin is driven low for 10 Mb/s and high for 100 Mb/s.
// R4 - In hardware mode the auto-negotiation pin is an input, high enabling it.
// R5 - In software mode the auto-negotiation pin is driven high when enabled, low when disabled.
// R6 - In hardware mode the duplex pin is an input, low for half and high for full duplex.
// R7 - In software mode the duplex pin is driven low while half duplex is configured.
// R8 - The descrambler lock output is high while lock is held and low otherwise.
// R9 - The link status pin is high while a link is up and low otherwise.
// R10 - Link status carries link state in MII or 10M serial mode and signal detect otherwise.
// R11 - Host interface select, link pulse select and speed together choose the MAC-side interface.
// R12 - Node/repeater select low means node operation and high means repeater operation.
// R13 - The board supplies the 25 MHz reference clock that runs this logic; the testbench stand-in clock runs at 40 MHz (25 ns period).
// R14 - The block is held in reset while the hardware reset pin is low.
// R15 - In software mode the duplex pin is driven high while full duplex is configured.
// R16 - In software mode the pins follow the internal control state and any change to it.
module pcs_config_pins
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              hw_reset_n,
    input  wire logic              strap_mode_select,
    input  wire logic              host_interface_select,
    input  wire logic              link_pulse_mode_select,
    input  wire logic              node_repeater_select,
    input  wire logic              speed_select_pin_in,
    output logic                   speed_select_pin_out,
    output logic                   speed_select_pin_oe,
    input  wire logic              autoneg_select_pin_in,
    output logic                   autoneg_select_pin_out,
    output logic                   autoneg_select_pin_oe,
    input  wire logic              duplex_select_pin_in,
    output logic                   duplex_select_pin_out,
    output logic                   duplex_select_pin_oe,
    input  wire logic              scrambler_lock_in,
    input  wire logic              link_up_in,
    input  wire logic              signal_detect,
    output logic                   descrambler_lock,
    output logic                   link_status_pin,
    output logic                   repeater_mode,
    output pcs_pkg::pcs_if_mode_t  if_mode,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic [31:0]            rdata
);
    import pcs_pkg::*;

    // Offsets must fit the address port; refused at elaboration
    if (ADDR_W < 3)
    begin
        $error("ADDR_W too small for the register map");
    end

    // Register hit decode, shared by write and read paths
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        reg_hit = (a == ADDR_W'(off));
    endfunction

    logic         rst_int;
    logic         sw_mode_ff;
    logic         host_if_ff;
    logic         lp_sel_ff;
    logic         repeater_ff;
    logic         ctrl_speed_ff;
    logic         ctrl_an_ff;
    logic         ctrl_duplex_ff;
    logic         cfg_speed_ff;
    logic         cfg_an_ff;
    logic         cfg_duplex_ff;
    logic         nxt_cfg_speed;
    logic         nxt_cfg_an;
    logic         nxt_cfg_duplex;
    pcs_if_mode_t if_mode_ff;
    pcs_if_mode_t nxt_if_mode;
    logic         link_sel;
    logic         lock_ff;
    logic         link_ff;
    logic [31:0]  status_word;
    logic [31:0]  nxt_rdata;
    logic [31:0]  rdata_ff;

    // R14 - reset pin combined
    assign rst_int = reset | ~hw_reset_n;

    // R1 - strap mode sampling
    // Straps track the pins during reset and freeze at release, so a late board settle is harmless
    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            sw_mode_ff  <= strap_mode_select;
            host_if_ff  <= host_interface_select;
            lp_sel_ff   <= link_pulse_mode_select;
            repeater_ff <= node_repeater_select;
        end
    end

    // R16 - software control state
    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            ctrl_speed_ff  <= PCS_CTRL_SPEED_RST;
            ctrl_an_ff     <= PCS_CTRL_AN_RST;
            ctrl_duplex_ff <= PCS_CTRL_DUPLEX_RST;
        end
        else if (wr_stb && reg_hit(addr, PCS_CTRL_OFF))
        begin
            ctrl_speed_ff  <= wdata[PCS_CTRL_SPEED_BIT];
            ctrl_an_ff     <= wdata[PCS_CTRL_AN_BIT];
            ctrl_duplex_ff <= wdata[PCS_CTRL_DUPLEX_BIT];
        end
    end

    // R2 R4 R6 - pins as inputs in hardware mode
    always_comb
    begin
        nxt_cfg_speed  = sw_mode_ff ? ctrl_speed_ff  : speed_select_pin_in;
        nxt_cfg_an     = sw_mode_ff ? ctrl_an_ff     : autoneg_select_pin_in;
        nxt_cfg_duplex = sw_mode_ff ? ctrl_duplex_ff : duplex_select_pin_in;
    end

    // Effective configuration
    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            cfg_speed_ff  <= 1'h0;
            cfg_an_ff     <= 1'h0;
            cfg_duplex_ff <= 1'h0;
        end
        else
        begin
            cfg_speed_ff  <= nxt_cfg_speed;
            cfg_an_ff     <= nxt_cfg_an;
            cfg_duplex_ff <= nxt_cfg_duplex;
        end
    end

    // R3 R5 R7 R15 - pins driven in software mode
    // Drivers stay off through reset so a strap resistor is never fought
    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            speed_select_pin_out   <= 1'h0;
            autoneg_select_pin_out <= 1'h0;
            duplex_select_pin_out  <= 1'h0;
            speed_select_pin_oe    <= 1'h0;
            autoneg_select_pin_oe  <= 1'h0;
            duplex_select_pin_oe   <= 1'h0;
        end
        else
        begin
            speed_select_pin_out   <= cfg_speed_ff;
            autoneg_select_pin_out <= cfg_an_ff;
            duplex_select_pin_out  <= cfg_duplex_ff;
            speed_select_pin_oe    <= sw_mode_ff;
            autoneg_select_pin_oe  <= sw_mode_ff;
            duplex_select_pin_oe   <= sw_mode_ff;
        end
    end

    // R11 - interface selection
    always_comb
    begin
        if (!host_if_ff)
        begin
            nxt_if_mode = PCS_IF_MII;
        end
        else if (cfg_speed_ff)
        begin
            nxt_if_mode = PCS_IF_SYM100;
        end
        else if (lp_sel_ff)
        begin
            nxt_if_mode = PCS_IF_LP;
        end
        else
        begin
            nxt_if_mode = PCS_IF_SER10;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            if_mode_ff <= PCS_IF_MII;
        end
        else
        begin
            if_mode_ff <= nxt_if_mode;
        end
    end

    // R10 - link status source
    always_comb
    begin
        case (if_mode_ff)
            PCS_IF_MII:    link_sel = link_up_in;
            PCS_IF_SER10:  link_sel = link_up_in;
            PCS_IF_SYM100: link_sel = signal_detect;
            PCS_IF_LP:     link_sel = signal_detect;
            default:       link_sel = 1'h0;
        endcase
    end

    // R8 R9 - status outputs, low while held in reset
    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            lock_ff <= 1'h0;
            link_ff <= 1'h0;
        end
        else
        begin
            lock_ff <= scrambler_lock_in;
            link_ff <= link_sel;
        end
    end

    // Status word and read data, zero outside the answer cycle
    always_comb
    begin
        status_word = 32'h0;
        status_word[PCS_ST_SWMODE_BIT] = sw_mode_ff;
        status_word[PCS_ST_SPEED_BIT]  = cfg_speed_ff;
        status_word[PCS_ST_AN_BIT]     = cfg_an_ff;
        status_word[PCS_ST_DUPLEX_BIT] = cfg_duplex_ff;
        status_word[PCS_ST_LOCK_BIT]   = lock_ff;
        status_word[PCS_ST_LINK_BIT]   = link_ff;
        status_word[PCS_ST_SD_BIT]     = signal_detect;
        status_word[PCS_ST_IFMODE_LSB +: 2] = if_mode_ff;
        status_word[PCS_ST_REP_BIT]    = repeater_ff;
        nxt_rdata = 32'h0;
        if (rd_stb && reg_hit(addr, PCS_CTRL_OFF))
        begin
            nxt_rdata[PCS_CTRL_SPEED_BIT]  = ctrl_speed_ff;
            nxt_rdata[PCS_CTRL_AN_BIT]     = ctrl_an_ff;
            nxt_rdata[PCS_CTRL_DUPLEX_BIT] = ctrl_duplex_ff;
        end
        else if (rd_stb && reg_hit(addr, PCS_STATUS_OFF))
        begin
            nxt_rdata = status_word;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            rdata_ff <= 32'h0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs straight from flip-flops; R13 clk is the board reference
    assign descrambler_lock = lock_ff;
    assign link_status_pin  = link_ff;
    assign if_mode          = if_mode_ff;
    assign rdata            = rdata_ff;

    // R12 - node or repeater default
    assign repeater_mode = repeater_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst_int);

    // Reset kept out of the steps, so the edge that releases reset never starts a check
    sequence s_sw3;
        (sw_mode_ff && !rst_int) [*3];
    endsequence

    sequence s_hw2;
        (!sw_mode_ff && !rst_int) [*2];
    endsequence

    a_mode_frozen: assert property ($past(!rst_int) |-> $stable(sw_mode_ff)) // R1
        else $error("strap mode changed outside reset");
    a_hw_pins_released: assert property (s_hw2 |-> !speed_select_pin_oe && !autoneg_select_pin_oe
        && !duplex_select_pin_oe) // R2
        else $error("pin driven in hardware mode");
    a_hw_speed_in: assert property (s_hw2 |-> cfg_speed_ff == $past(speed_select_pin_in)) // R2
        else $error("hardware speed not taken from pin");
    a_sw_speed_out: assert property (s_sw3 |-> speed_select_pin_oe
        && speed_select_pin_out == $past(ctrl_speed_ff, 2)) // R3
        else $error("speed pin does not follow control");
    a_hw_an_in: assert property (s_hw2 |-> cfg_an_ff == $past(autoneg_select_pin_in)) // R4
        else $error("hardware autoneg not taken from pin");
    a_sw_an_out: assert property (s_sw3 |-> autoneg_select_pin_oe
        && autoneg_select_pin_out == $past(ctrl_an_ff, 2)) // R5
        else $error("autoneg pin does not follow control");
    a_hw_dpx_in: assert property (s_hw2 |-> cfg_duplex_ff == $past(duplex_select_pin_in)) // R6
        else $error("hardware duplex not taken from pin");
    a_sw_dpx_out: assert property (s_sw3 |-> duplex_select_pin_oe
        && duplex_select_pin_out == $past(ctrl_duplex_ff, 2)) // R15
        else $error("duplex pin does not follow control");
    a_lock_follow: assert property ($past(!rst_int) |-> descrambler_lock == $past(scrambler_lock_in)) // R8
        else $error("lock output does not follow lock");
    a_link_source: assert property ($past(!rst_int) |-> link_status_pin == $past(
        (if_mode_ff == PCS_IF_MII || if_mode_ff == PCS_IF_SER10) ? link_up_in : signal_detect)) // R10
        else $error("link status from wrong source");
    a_if_mii: assert property ($past(!rst_int) && !host_if_ff |-> if_mode_ff == PCS_IF_MII) // R11
        else $error("host select low must give MII");
    a_ctrl_write: assert property (wr_stb && reg_hit(addr, PCS_CTRL_OFF) ##1 s_sw3
        |-> speed_select_pin_out == $past(wdata[PCS_CTRL_SPEED_BIT], 3)) // R16
        else $error("written speed not on pin");
    a_rep_frozen: assert property ($past(!rst_int) |-> $stable(repeater_mode)) // R12
        else $error("repeater default changed outside reset");

endmodule

`default_nettype wire

// ==== pkg/pcs_pkg.sv ====
// Shared constants and types for the configuration strap pin block
package pcs_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] PCS_CTRL_OFF   = 8'h00;
    localparam logic [7:0] PCS_STATUS_OFF = 8'h04;

    // Control register field positions
    localparam int PCS_CTRL_SPEED_BIT  = 0;
    localparam int PCS_CTRL_AN_BIT     = 1;
    localparam int PCS_CTRL_DUPLEX_BIT = 2;

    // Control register reset values
    localparam logic PCS_CTRL_SPEED_RST  = 1'h1;
    localparam logic PCS_CTRL_AN_RST     = 1'h1;
    localparam logic PCS_CTRL_DUPLEX_RST = 1'h0;

    // Status register field positions
    localparam int PCS_ST_SWMODE_BIT = 0;
    localparam int PCS_ST_SPEED_BIT  = 1;
    localparam int PCS_ST_AN_BIT     = 2;
    localparam int PCS_ST_DUPLEX_BIT = 3;
    localparam int PCS_ST_LOCK_BIT   = 4;
    localparam int PCS_ST_LINK_BIT   = 5;
    localparam int PCS_ST_SD_BIT     = 6;
    localparam int PCS_ST_IFMODE_LSB = 7;
    localparam int PCS_ST_REP_BIT    = 9;

    // MAC-side interface selection
    typedef enum logic [1:0]
    {
        PCS_IF_MII    = 2'b00,
        PCS_IF_SYM100 = 2'b01,
        PCS_IF_SER10  = 2'b10,
        PCS_IF_LP     = 2'b11
    } pcs_if_mode_t;

endpackage

// ==== tb/pcs_board_model.sv ====
// Board side model: strap resistors on the shared configuration pins
`timescale 1ns/1ps
`default_nettype none

module pcs_board_model
(
    input  wire logic [2:0] strap_lvl,
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    output logic [2:0]      pin_in
);
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : strap_lvl[i];
        end
    end
endmodule

`default_nettype wire

// ==== tb/test_pcs_config_pins.sv ====
// Self-checking testbench for the configuration strap pin block
`timescale 1ns/1ps
`default_nettype none

module test_pcs_config_pins;
    import pcs_pkg::*;
    logic          clk, reset, hw_reset_n, mode_sel, host_sel, lp_sel, rep_sel;
    logic          lock_in, link_in, sd, lock_out, lstat, rep_mode, wr_stb, rd_stb;
    logic [2:0]    strap_lvl, pin_in, pin_out, pin_oe;
    pcs_if_mode_t  ifm;
    logic [7:0]    addr;
    logic [31:0]   wdata, rdata, rv;
    int            err_total, tests_run, cycles;

    pcs_config_pins i_pcs_config_pins (.clk(clk), .reset(reset), .hw_reset_n(hw_reset_n),
        .strap_mode_select(mode_sel), .host_interface_select(host_sel), .link_pulse_mode_select(lp_sel),
        .node_repeater_select(rep_sel), .speed_select_pin_in(pin_in[0]), .speed_select_pin_out(pin_out[0]),
        .speed_select_pin_oe(pin_oe[0]), .autoneg_select_pin_in(pin_in[1]), .autoneg_select_pin_out(pin_out[1]),
        .autoneg_select_pin_oe(pin_oe[1]), .duplex_select_pin_in(pin_in[2]), .duplex_select_pin_out(pin_out[2]),
        .duplex_select_pin_oe(pin_oe[2]), .scrambler_lock_in(lock_in), .link_up_in(link_in), .signal_detect(sd),
        .descrambler_lock(lock_out), .link_status_pin(lstat), .repeater_mode(rep_mode), .if_mode(ifm),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

    pcs_board_model i_pcs_board_model (.strap_lvl(strap_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    // stand-in for the board reference clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic conclude;
        $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        if (seen !== exp)
            err_total++;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rdata;
        // Hand back on a rising edge so callers drive right after it
        @(posedge clk);
    endtask

    // Straps {rep, lp, host, mode}; either reset input may hold the block
    task automatic do_reset(input logic [3:0] straps, input logic use_pin);
        @(posedge clk);
        if (use_pin)
            hw_reset_n <= 1'b0;
        else
            reset <= 1'b1;
        {rep_sel, lp_sel, host_sel, mode_sel} <= straps;
        repeat (6) @(posedge clk);
        #1;
        chk({pin_oe, lock_out, lstat}, 32'h0);
        @(posedge clk);
        reset      <= 1'b0;
        hw_reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial
    begin
        {reset, hw_reset_n, wr_stb, rd_stb, lock_in, link_in, sd} = 7'b1100000;
        {mode_sel, host_sel, lp_sel, rep_sel} = 4'h0;
        strap_lvl = 3'h0;
        addr = 8'h00;
        wdata = 32'h0;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        do_reset(4'h0, 1'b0);
        // Hardware mode: pins are inputs; control writes must not reach them
        reg_wr(PCS_CTRL_OFF, 32'h0000_0007);
        for (int i = 0; i < 8; i++)
        begin
            strap_lvl <= i[2:0];
            repeat (3) @(posedge clk);
            #1;
            chk(pin_oe, 32'h0);
            reg_rd(PCS_STATUS_OFF, rv);
            chk(rv, {28'h0, i[2:0], 1'b0});
        end
        $display("Test hardware strap pins done");
        // Lock and link follow their sources one cycle later
        @(posedge clk);
        {lock_in, link_in, sd} <= 3'b111;
        @(posedge clk);
        #1;
        chk({lock_out, lstat}, 32'h3);
        reg_rd(PCS_STATUS_OFF, rv);
        chk(rv, 32'h0000_007e);
        @(posedge clk);
        {lock_in, link_in, sd} <= 3'b010;
        @(posedge clk);
        #1;
        chk({lock_out, lstat}, 32'h1);
        $display("Test lock and link done");
        // Every interface decode, link source and node/repeater strap
        for (int j = 0; j < 8; j++)
        begin
            @(posedge clk);
            // Link and signal detect differ, so a wrong source shows
            {link_in, sd} <= {~j[0], j[0]};
            strap_lvl <= {2'b00, j[0]};
            do_reset({j[0], j[2], j[1], 1'b0}, j[0]);
            rv = !j[1] ? 32'(PCS_IF_MII) : j[0] ? 32'(PCS_IF_SYM100) : j[2] ? 32'(PCS_IF_LP) : 32'(PCS_IF_SER10);
            chk({30'h0, ifm}, rv);
            chk(lstat, (rv == 32'(PCS_IF_MII) || rv == 32'(PCS_IF_SER10)) ? {31'h0, ~j[0]} : {31'h0, j[0]});
            chk(rep_mode, j[0]);
        end
        $display("Test interface modes done");
        // Software mode: pins driven from control state, straps ignored
        @(posedge clk);
        strap_lvl <= 3'b100;
        do_reset(4'h1, 1'b1);
        chk({pin_oe, pin_out}, 32'h3b);
        for (int k = 0; k < 8; k++)
        begin
            reg_wr(PCS_CTRL_OFF, 32'(k));
            repeat (4) @(posedge clk);
            #1;
            chk({pin_oe, pin_out}, {26'h0, 3'b111, k[2:0]});
            reg_rd(PCS_CTRL_OFF, rv);
            chk(rv, 32'(k));
            reg_rd(PCS_STATUS_OFF, rv);
            chk(rv[3:0], {28'h0, k[2:0], 1'b1});
        end
        reg_wr(PCS_STATUS_OFF, 32'hffff_ffff);
        reg_rd(PCS_CTRL_OFF, rv);
        chk(rv, 32'h7);
        reg_rd(8'h08, rv);
        chk(rv, 32'h0);
        $display("Test software mode done");
        conclude();
    end
endmodule

`default_nettype wire
